// ===== asd_consts.svh
// constants of the address-space decoder
`ifndef ASD_CONSTS_SVH
`define ASD_CONSTS_SVH
`define ASD_REGION_DATA      8'h00
`define ASD_REGION_EXT       8'h01
`define ASD_REGION_EXT_HI    8'hfe
`define ASD_REGION_CODE      8'hff
`define ASD_BANK_TOP         16'h001f
`define ASD_GP_RAM_BASE      16'h0020
`define ASD_GP_RAM_TOP       16'h041f
`define ASD_CODE_TOP         16'h3fff
`define ASD_RESET_VECTOR     24'hff0000
`define ASD_SR_DPRB          9'h084
`define ASD_SR_ACC           9'h0e0
`define ASD_SR_B             9'h0f0
`define ASD_SR_SPL           9'h081
`define ASD_SR_DPL           9'h082
`define ASD_SR_DPH           9'h083
`define ASD_SR_SPH           9'h0be
`define ASD_SR_LEGACY_BASE   9'h080
`define ASD_RF_B             6'd10
`define ASD_RF_ACC           6'd11
`define ASD_RF_DPRB          6'd57
`define ASD_RF_DPH           6'd58
`define ASD_RF_DPL           6'd59
`define ASD_RF_SPH           6'd62
`define ASD_RF_SPL           6'd63
`define ASD_RF_RES_LO        6'd32
`define ASD_RF_RES_HI        6'd55
`define ASD_DPRB_RESET       8'h01
`define ASD_EXT_LINES        18
`define ASD_RAM_WORDS        1056
`endif

// ===== asd_pkg.sv
// types of the address-space decoder
`default_nettype none
package asd_pkg;
    typedef enum logic [2:0] {
        ASD_TGT_BANK     = 3'h0,
        ASD_TGT_RAM      = 3'h1,
        ASD_TGT_CODE     = 3'h3,
        ASD_TGT_EXT      = 3'h2,
        ASD_TGT_RESERVED = 3'h6
    } asd_target_t;
    typedef enum logic [1:0] {
        ASD_ACC_DATA   = 2'h0,
        ASD_ACC_FETCH  = 2'h1,
        ASD_ACC_LCODE  = 2'h3,
        ASD_ACC_LXDATA = 2'h2
    } asd_access_t;
endpackage
`default_nettype wire

// ===== asd_ram_if.sv
// carrier between decoder and its on-chip ram
`timescale 1ns/1ps
`default_nettype none
interface asd_ram_if;
    logic        we;
    logic        re;
    logic [10:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    modport ctrl (output we, output re, output addr, output wdata, input rdata);
    modport mem  (input we, input re, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// ===== asd_ram.sv
// on-chip data ram: register banks plus general ram
`timescale 1ns/1ps
`default_nettype none
`include "asd_consts.svh"
module asd_ram (
    input wire logic core_clk,
    asd_ram_if.mem   port
);
    logic [7:0] mem_q [0:`ASD_RAM_WORDS-1];
    logic [7:0] rdata_q;

    always_ff @(posedge core_clk) begin
        if (port.we) begin
            mem_q[port.addr] <= port.wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (port.re) begin
            rdata_q <= mem_q[port.addr];
        end
    end

    assign port.rdata = rdata_q;
endmodule
`default_nettype wire

// ===== asd_decoder.sv
// address-space decoder: memory, special-register and register-file spaces
// Function
// - flat 16M space, 256 regions by top byte
// - on-chip code sits inside region ff
// - banks at 00:0000-001f, ram from 0020
// - 64 file locations, 0-7 banked
// - file locations 8-63 not in memory
// - separate 512-entry special-register space decoded
// - legacy code reads to ff; fetches keep their region
// - legacy external data region from pointer byte
// - region byte at file 57 and s:084
// - region byte resets to 01, writable
// - legacy internal data at 00:0000-00ff
// - legacy special registers kept from s:080
// - acc, b, dptr, sp aliased in file
// - regions 00,01,fe,ff usable; start ff:0000
// - regions 02-fd reserved, writes dropped
// - at most 18 external address lines
// - status bits pick active register bank
// - file 32-55 reserved and inaccessible
// - on-chip fetch only when strap is 1
`timescale 1ns/1ps
`default_nettype none
`include "asd_consts.svh"
module asd_decoder
    import asd_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        external_access_select,
    input  wire logic        bank_select_high,
    input  wire logic        bank_select_low,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [1:0]  mem_kind,
    input  wire logic [23:0] mem_addr,
    input  wire logic [7:0]  mem_wdata,
    output var  logic        mem_ack,
    output var  logic [7:0]  mem_rdata,
    output var  logic [2:0]  mem_target,
    output var  logic [23:0] mem_phys_addr,
    output var  logic        ext_req,
    output var  logic [17:0] ext_addr,
    output var  logic        code_req,
    output var  logic [15:0] code_addr,
    input  wire logic [7:0]  code_rdata,
    input  wire logic [7:0]  ext_rdata,
    input  wire logic        sr_req,
    input  wire logic        sr_we,
    input  wire logic [8:0]  sr_addr,
    input  wire logic [7:0]  sr_wdata,
    output var  logic        sr_ack,
    output var  logic [7:0]  sr_rdata,
    output var  logic        sr_hit,
    input  wire logic        rf_req,
    input  wire logic        rf_we,
    input  wire logic [5:0]  rf_addr,
    input  wire logic [7:0]  rf_wdata,
    output var  logic        rf_ack,
    output var  logic [7:0]  rf_rdata,
    output var  logic        rf_err,
    output var  logic [23:0] reset_vector,
    output var  logic [7:0]  data_pointer_region_byte
);
    asd_ram_if ram_bus ();
    asd_ram u_ram (.core_clk(core_clk), .port(ram_bus));

    // cpu-held registers: file 8-31 and 56-63
    logic [7:0]  rf_q [8:63];
    logic        ea_s1_q, ea_s2_q, ea_s3_q, ea_lat_q, in_rst_q;
    logic        ram_pend_q, rf_bank_pend_q;
    logic [7:0]  dprb_q;
    asd_target_t tgt;
    logic [23:0] phys;

    // region index is the top byte; no segment registers
    function automatic asd_target_t decode(input logic [23:0] a, input logic [1:0] k,
                                           input logic ea);
        logic [7:0]  rg;
        logic [15:0] off;
        rg  = a[23:16];
        off = a[15:0];
        if (rg == `ASD_REGION_DATA) begin
            if (off <= `ASD_BANK_TOP) decode = ASD_TGT_BANK;
            else if (off <= `ASD_GP_RAM_TOP && k != 2'(ASD_ACC_FETCH))
                decode = ASD_TGT_RAM;
            else decode = ASD_TGT_EXT;
        end else if (rg == `ASD_REGION_CODE) begin
            // on-chip code inside ff, else external
            if (off <= `ASD_CODE_TOP && ea) decode = ASD_TGT_CODE;
            else decode = ASD_TGT_EXT;
        end else if (rg == `ASD_REGION_EXT || rg == `ASD_REGION_EXT_HI) begin
            decode = ASD_TGT_EXT;
        end else begin
            decode = ASD_TGT_RESERVED;
        end
    endfunction

    // legacy remaps ahead of decode
    always_comb begin
        case (asd_access_t'(mem_kind))
            ASD_ACC_LCODE:  phys = {`ASD_REGION_CODE, mem_addr[15:0]};
            ASD_ACC_LXDATA: phys = {dprb_q, mem_addr[15:0]};
            ASD_ACC_DATA:   phys = mem_addr;
            ASD_ACC_FETCH:  phys = mem_addr;
            default:        phys = mem_addr;
        endcase
        tgt = decode(phys, mem_kind, ea_lat_q);
    end

    // strap synchroniser; latched at reset exit
    always_ff @(posedge core_clk) begin
        ea_s1_q <= external_access_select;
        ea_s2_q <= ea_s1_q;
        ea_s3_q <= ea_s2_q;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            in_rst_q <= 1'b1;
            ea_lat_q <= 1'b0;
        end else begin
            in_rst_q <= 1'b0;
            if (in_rst_q && ea_s2_q == ea_s3_q) ea_lat_q <= ea_s3_q;
        end
    end

    // which special address is an alias of which file slot
    function automatic logic [6:0] sr_alias(input logic [8:0] a);
        case (a)
            `ASD_SR_ACC:  sr_alias = {1'b1, `ASD_RF_ACC};
            `ASD_SR_B:    sr_alias = {1'b1, `ASD_RF_B};
            `ASD_SR_DPL:  sr_alias = {1'b1, `ASD_RF_DPL};
            `ASD_SR_DPH:  sr_alias = {1'b1, `ASD_RF_DPH};
            `ASD_SR_SPL:  sr_alias = {1'b1, `ASD_RF_SPL};
            `ASD_SR_SPH:  sr_alias = {1'b1, `ASD_RF_SPH};
            `ASD_SR_DPRB: sr_alias = {1'b1, `ASD_RF_DPRB};
            default:      sr_alias = 7'h00;
        endcase
    endfunction

    function automatic logic rf_ok(input logic [5:0] a);
        rf_ok = !(a >= `ASD_RF_RES_LO && a <= `ASD_RF_RES_HI);
    endfunction

    logic [6:0]  sr_map;
    logic [4:0]  bank_addr;
    logic        rf_bank, mem_bank, mem_ram;
    logic        rf_wr, sr_wr;
    assign sr_map    = sr_alias(sr_addr);
    assign bank_addr = {bank_select_high, bank_select_low, rf_addr[2:0]};
    assign rf_bank   = rf_req && rf_addr < 6'd8;
    assign mem_bank  = mem_req && tgt == ASD_TGT_BANK;
    assign mem_ram   = mem_req && (tgt == ASD_TGT_BANK || tgt == ASD_TGT_RAM);
    assign rf_wr     = rf_req && rf_we && rf_addr >= 6'd8 && rf_ok(rf_addr);
    assign sr_wr     = sr_req && sr_we && sr_map[6];

    // ram port: memory side wins; a banked file request in the same cycle is dropped without an ack
    always_comb begin
        ram_bus.we    = 1'b0;
        ram_bus.re    = 1'b0;
        ram_bus.addr  = 11'h000;
        ram_bus.wdata = 8'h00;
        if (mem_ram) begin
            ram_bus.we    = mem_we;
            ram_bus.re    = !mem_we;
            ram_bus.addr  = phys[10:0];
            ram_bus.wdata = mem_wdata;
        end else if (rf_bank) begin
            ram_bus.we    = rf_we;
            ram_bus.re    = !rf_we;
            ram_bus.addr  = {6'h00, bank_addr};
            ram_bus.wdata = rf_wdata;
        end
    end

    // file registers; file slot 57 and s:084 share one flop
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            dprb_q <= `ASD_DPRB_RESET;
        end else if (rf_wr && rf_addr == `ASD_RF_DPRB) begin
            dprb_q <= rf_wdata;
        end else if (sr_wr && sr_map[5:0] == `ASD_RF_DPRB) begin
            dprb_q <= sr_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rf_wr && rf_addr != `ASD_RF_DPRB) begin
            rf_q[rf_addr] <= rf_wdata;
        end else if (sr_wr && sr_map[5:0] != `ASD_RF_DPRB) begin
            rf_q[sr_map[5:0]] <= sr_wdata;
        end
    end

    function automatic logic [7:0] rf_read(input logic [5:0] a);
        if (a == `ASD_RF_DPRB) rf_read = dprb_q;
        else if (a >= 6'd8 && rf_ok(a)) rf_read = rf_q[a];
        else rf_read = 8'h00;
    endfunction

    // register-file answers; banked reads come from the ram next cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rf_ack         <= 1'b0;
            rf_rdata       <= 8'h00;
            rf_err         <= 1'b0;
            rf_bank_pend_q <= 1'b0;
        end else begin
            rf_bank_pend_q <= 1'b0;
            rf_ack         <= 1'b0;
            rf_err         <= 1'b0;
            if (rf_bank_pend_q) begin
                rf_ack   <= 1'b1;
                rf_rdata <= ram_bus.rdata;
            end else if (rf_req && rf_bank && !mem_ram) begin
                rf_bank_pend_q <= !rf_we;
                rf_ack         <= rf_we;
            end else if (rf_req && !rf_bank) begin
                rf_ack   <= 1'b1;
                rf_err   <= !rf_ok(rf_addr);
                rf_rdata <= rf_read(rf_addr);
            end
        end
    end

    // special-register answers; unknown addresses read 00, writes dropped
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sr_ack   <= 1'b0;
            sr_rdata <= 8'h00;
            sr_hit   <= 1'b0;
        end else begin
            sr_ack <= sr_req;
            sr_hit <= sr_req && sr_map[6];
            if (sr_req) sr_rdata <= sr_map[6] ? rf_read(sr_map[5:0]) : 8'h00;
        end
    end

    // memory answers: ram reads take two cycles, ram writes and others one
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mem_ack       <= 1'b0;
            mem_rdata     <= 8'h00;
            mem_target    <= 3'(ASD_TGT_RESERVED);
            mem_phys_addr <= 24'h000000;
            ext_req       <= 1'b0;
            ext_addr      <= 18'h00000;
            code_req      <= 1'b0;
            code_addr     <= 16'h0000;
            ram_pend_q    <= 1'b0;
        end else begin
            mem_ack    <= 1'b0;
            ext_req    <= 1'b0;
            code_req   <= 1'b0;
            ram_pend_q <= 1'b0;
            if (ram_pend_q) begin
                mem_ack   <= 1'b1;
                mem_rdata <= ram_bus.rdata;
            end else if (mem_req) begin
                mem_target    <= 3'(tgt);
                mem_phys_addr <= phys;
                case (tgt)
                    ASD_TGT_BANK, ASD_TGT_RAM: begin
                        ram_pend_q <= !mem_we;
                        mem_ack    <= mem_we;
                    end
                    ASD_TGT_CODE: begin
                        code_req  <= !mem_we;
                        code_addr <= phys[15:0];
                        mem_ack   <= 1'b1;
                        mem_rdata <= code_rdata;
                    end
                    ASD_TGT_EXT: begin
                        ext_req   <= 1'b1;
                        ext_addr  <= {phys[23], phys[16], phys[15:0]};
                        mem_ack   <= 1'b1;
                        mem_rdata <= ext_rdata;
                    end
                    default: begin
                        mem_ack   <= 1'b1;
                        mem_rdata <= 8'h00;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reset_vector             <= `ASD_RESET_VECTOR;
            data_pointer_region_byte <= `ASD_DPRB_RESET;
        end else begin
            reset_vector             <= `ASD_RESET_VECTOR;
            data_pointer_region_byte <= dprb_q;
        end
    end

    AST_DPRB_RESET: assert property (@(posedge core_clk)
        $rose(rst_n) |-> dprb_q == `ASD_DPRB_RESET)
        else $error("region byte not 01 after reset");
    AST_LXDATA: assert property (@(posedge core_clk) disable iff (!rst_n)
        mem_req && mem_kind == 2'(ASD_ACC_LXDATA) |=> mem_phys_addr[23:16] == $past(dprb_q))
        else $error("legacy external data not in pointer region");
    AST_LCODE: assert property (@(posedge core_clk) disable iff (!rst_n)
        mem_req && mem_kind == 2'(ASD_ACC_LCODE) |=> mem_phys_addr[23:16] == `ASD_REGION_CODE)
        else $error("legacy code read not in region ff");
    AST_RESERVED: assert property (@(posedge core_clk) disable iff (!rst_n)
        mem_req && phys[23:16] > 8'h01 && phys[23:16] < 8'hfe
        |-> !ram_bus.we ##1 mem_ack && !ext_req)
        else $error("reserved region access stored or went external");
    sequence asd_file_dprb_write_s;
        rf_req && rf_we && rf_addr == `ASD_RF_DPRB && !sr_req ##1 !rf_req && !sr_req;
    endsequence
    AST_SR_ALIAS: assert property (@(posedge core_clk) disable iff (!rst_n)
        asd_file_dprb_write_s ##1 sr_req && !sr_we && sr_addr == `ASD_SR_DPRB && !rf_req
        |=> sr_rdata == $past(rf_wdata, 3))
        else $error("views of region byte differ");
    AST_RF_RSVD: assert property (@(posedge core_clk) disable iff (!rst_n)
        rf_req && rf_addr >= 6'd32 && rf_addr <= 6'd55 |=> rf_err && rf_rdata == 8'h00)
        else $error("reserved file slot accessible");
    AST_BANK: assert property (@(posedge core_clk) disable iff (!rst_n)
        rf_req && rf_addr < 6'd8 && !mem_ram
        |-> ram_bus.addr[4:3] == {bank_select_high, bank_select_low})
        else $error("wrong bank selected");
    AST_CODE_EA: assert property (@(posedge core_clk) disable iff (!rst_n)
        code_req |-> ea_lat_q && mem_phys_addr[23:16] == `ASD_REGION_CODE)
        else $error("on-chip code used with strap low");
    AST_SR_UNIMP: assert property (@(posedge core_clk) disable iff (!rst_n)
        sr_req && sr_alias(sr_addr) == 7'h00 |=> sr_ack && !sr_hit && sr_rdata == 8'h00)
        else $error("unimplemented special register answered");
endmodule
`default_nettype wire

// ===== asd_mem_model.sv
// code memory and external memory model on the far side of the decoder
`timescale 1ns/1ps
`default_nettype none
module asd_mem_model (
    input  wire logic        core_clk,
    input  wire logic        mem_req,
    input  wire logic [23:0] mem_addr,
    output var  logic [7:0]  code_rdata,
    output var  logic [7:0]  ext_rdata
);
    logic [7:0] noise_q = 8'h00;
    // idle data lines keep moving so a stale or late sample never matches
    always @(posedge core_clk) begin
        noise_q <= noise_q + 8'h3b;
    end
    always_comb begin
        code_rdata = mem_req ? (mem_addr[7:0] ^ 8'h5a) : noise_q;
        ext_rdata  = mem_req ? (mem_addr[7:0] ^ mem_addr[15:8] ^ 8'ha5) : ~noise_q;
    end
endmodule
`default_nettype wire

// ===== address_space_decoder_bench.sv
// self-checking bench for the address-space decoder
`timescale 1ns/1ps
`default_nettype none
`include "asd_consts.svh"
module address_space_decoder_bench
    import asd_pkg::*;
;
    logic        core_clk, rst_n, external_access_select, bank_select_high, bank_select_low;
    logic        mem_req, mem_we, mem_ack, ext_req, code_req;
    logic [1:0]  mem_kind;
    logic [23:0] mem_addr, mem_phys_addr, reset_vector;
    logic [7:0]  mem_wdata, mem_rdata, code_rdata, ext_rdata;
    logic [2:0]  mem_target;
    logic [17:0] ext_addr, ext_got;
    logic [15:0] code_addr, code_got;
    logic        sr_req, sr_we, sr_ack, sr_hit, rf_req, rf_we, rf_ack, rf_err;
    logic [8:0]  sr_addr;
    logic [7:0]  sr_wdata, sr_rdata, rf_wdata, rf_rdata, data_pointer_region_byte;
    logic [5:0]  rf_addr;
    logic        seen_ext, seen_code;
    int          failures, n_tests, cycles;
    logic [8:0]  sr_tab [7] = '{9'h0e0, 9'h0f0, 9'h082, 9'h083, 9'h081, 9'h0be, 9'h084};
    logic [5:0]  rf_tab [7] = '{6'd11, 6'd10, 6'd59, 6'd58, 6'd63, 6'd62, 6'd57};
    logic [7:0]  res_tab [3] = '{8'h02, 8'h7f, 8'hfd};

    asd_decoder dut_u (
        .core_clk, .rst_n, .external_access_select, .bank_select_high, .bank_select_low,
        .mem_req, .mem_we, .mem_kind, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
        .mem_target, .mem_phys_addr, .ext_req, .ext_addr, .code_req, .code_addr,
        .code_rdata, .ext_rdata, .sr_req, .sr_we, .sr_addr, .sr_wdata, .sr_ack, .sr_rdata,
        .sr_hit, .rf_req, .rf_we, .rf_addr, .rf_wdata, .rf_ack, .rf_rdata, .rf_err,
        .reset_vector, .data_pointer_region_byte
    );
    asd_mem_model mem_u (
        .core_clk, .mem_req, .mem_addr, .code_rdata, .ext_rdata
    );

    always #12.5 core_clk = ~core_clk;

    function automatic logic [7:0] ext_byte(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ 8'ha5;
    endfunction

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // sp 0 memory, 1 special register, 2 register file; request is a one-cycle pulse
    task automatic acc(input int sp, input logic we, input logic [23:0] a,
                       input logic [7:0] wd, input logic [1:0] kind = 2'h0);
        int   n;
        logic ack;
        @(negedge core_clk);
        case (sp)
            0: begin
                mem_req = 1'b1;
                mem_we = we;
                mem_kind = kind;
                mem_addr = a;
                mem_wdata = wd;
            end
            1: begin
                sr_req = 1'b1;
                sr_we = we;
                sr_addr = a[8:0];
                sr_wdata = wd;
            end
            default: begin
                rf_req = 1'b1;
                rf_we = we;
                rf_addr = a[5:0];
                rf_wdata = wd;
            end
        endcase
        @(negedge core_clk);
        mem_req = 1'b0;
        sr_req = 1'b0;
        rf_req = 1'b0;
        seen_ext = 1'b0;
        seen_code = 1'b0;
        for (n = 0; n < 4; n++) begin
            if (ext_req === 1'b1) begin
                seen_ext = 1'b1;
                ext_got = ext_addr;
            end
            if (code_req === 1'b1) begin
                seen_code = 1'b1;
                code_got = code_addr;
            end
            ack = (sp == 0) ? mem_ack : (sp == 1) ? sr_ack : rf_ack;
            if (ack === 1'b1)
                break;
            @(negedge core_clk);
        end
        if (n == 4) begin
            failures++;
            $display("Error ack expected 1 seen 0");
        end
    endtask

    task automatic mem_chk(input logic [1:0] k, input logic [23:0] a, input logic [2:0] tgt,
                           input logic [7:0] d, input logic [23:0] ph);
        acc(0, 1'b0, a, 8'h00, k);
        chk("mem_target", tgt, mem_target);
        chk("mem_rdata", d, mem_rdata);
        chk("mem_phys_addr", ph, mem_phys_addr);
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            $display("Error timeout expected done seen running");
            stop_test();
        end
    end

    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        external_access_select = 1'b1;
        {bank_select_high, bank_select_low} = 2'b00;
        {mem_req, mem_we, sr_req, sr_we, rf_req, rf_we} = 6'h00;
        mem_kind = 2'h0;
        mem_addr = 24'h000000;
        {mem_wdata, sr_wdata, rf_wdata} = 24'h000000;
        sr_addr = 9'h000;
        rf_addr = 6'h00;
        repeat (5) @(negedge core_clk);
        rst_n = 1'b1;
        chk("region_byte", 8'h01, data_pointer_region_byte);
        chk("reset_vector", `ASD_RESET_VECTOR, reset_vector);
        acc(1, 1'b0, `ASD_SR_DPRB, 8'h00);
        chk("sr_rdata", 8'h01, sr_rdata);
        acc(2, 1'b0, `ASD_RF_DPRB, 8'h00);
        chk("rf_rdata", 8'h01, rf_rdata);
        $display("test reset done");
        foreach (res_tab[i]) begin
            acc(0, 1'b1, {8'h00, i[7:0], 8'h20 + i[7:0]}, 8'h60 + i[7:0]);
            mem_chk(2'h0, {8'h00, i[7:0], 8'h20 + i[7:0]}, ASD_TGT_RAM, 8'h60 + i[7:0],
                    {8'h00, i[7:0], 8'h20 + i[7:0]});
        end
        acc(0, 1'b1, 24'h00041f, 8'h4f);
        mem_chk(2'h0, 24'h00041f, ASD_TGT_RAM, 8'h4f, 24'h00041f);
        $display("test ram done");
        for (int b = 0; b < 4; b++) begin
            {bank_select_high, bank_select_low} = b[1:0];
            acc(2, 1'b1, 24'd3, 8'hc0 + b[7:0]);
        end
        for (int b = 0; b < 4; b++) begin
            mem_chk(2'h0, 24'h000003 + 24'h8 * b[23:0], ASD_TGT_BANK, 8'hc0 + b[7:0],
                    24'h000003 + 24'h8 * b[23:0]);
        end
        acc(0, 1'b1, 24'h000014, 8'h11);
        acc(2, 1'b1, 24'd20, 8'h77);
        mem_chk(2'h0, 24'h000014, ASD_TGT_BANK, 8'h11, 24'h000014);
        acc(2, 1'b0, 24'd20, 8'h00);
        chk("rf_rdata", 8'h77, rf_rdata);
        $display("test banks done");
        foreach (res_tab[i]) begin
            acc(2, 1'b0, 24'd31 + 24'd1 * i + (i == 2 ? 24'd22 : 24'd0), 8'h00);
            chk("rf_err", (i != 0), rf_err);
        end
        acc(2, 1'b0, 24'd56, 8'h00);
        chk("rf_err", 1'b0, rf_err);
        $display("test file done");
        foreach (sr_tab[i]) begin
            acc(1, 1'b1, sr_tab[i], 8'h30 + i[7:0]);
            acc(2, 1'b0, rf_tab[i], 8'h00);
            chk("rf_rdata", 8'h30 + i[7:0], rf_rdata);
            acc(2, 1'b1, rf_tab[i], 8'h90 + i[7:0]);
            acc(1, 1'b0, sr_tab[i], 8'h00);
            chk("sr_rdata", 8'h90 + i[7:0], sr_rdata);
            chk("sr_hit", 1'b1, sr_hit);
        end
        chk("region_byte", 8'h96, data_pointer_region_byte);
        acc(1, 1'b1, 24'h0001ff, 8'h55);
        acc(1, 1'b0, 24'h0001ff, 8'h00);
        chk("sr_rdata", 8'h00, sr_rdata);
        chk("sr_hit", 1'b0, sr_hit);
        acc(0, 1'b1, 24'h000084, 8'h44);
        acc(1, 1'b0, `ASD_SR_DPRB, 8'h00);
        chk("sr_rdata", 8'h96, sr_rdata);
        $display("test special done");
        for (int r = 0; r < 2; r++) begin
            acc(1, 1'b1, `ASD_SR_DPRB, r ? 8'hfe : 8'h01);
            mem_chk(2'h2, 24'h001234, ASD_TGT_EXT, ext_byte(24'h001234),
                    {r ? 8'hfe : 8'h01, 16'h1234});
            chk("ext_addr", {r[0], ~r[0], 16'h1234}, seen_ext ? ext_got : 18'h0);
        end
        mem_chk(2'h3, 24'h000100, ASD_TGT_CODE, 8'h00 ^ 8'h5a, 24'hff0100);
        chk("code_addr", 16'h0100, seen_code ? code_got : 16'h0);
        mem_chk(2'h3, 24'h008000, ASD_TGT_EXT, ext_byte(24'h008000), 24'hff8000);
        chk("ext_addr", 18'h38000, seen_ext ? ext_got : 18'h0);
        mem_chk(2'h1, 24'hff0000, ASD_TGT_CODE, 8'h5a, 24'hff0000);
        mem_chk(2'h1, 24'h010010, ASD_TGT_EXT, ext_byte(24'h010010), 24'h010010);
        mem_chk(2'h1, 24'hfefff0, ASD_TGT_EXT, ext_byte(24'hfefff0), 24'hfefff0);
        chk("ext_addr", 18'h2fff0, seen_ext ? ext_got : 18'h0);
        $display("test legacy done");
        foreach (res_tab[i]) begin
            acc(0, 1'b1, {res_tab[i], 16'h0010}, 8'haa);
            mem_chk(2'h0, {res_tab[i], 16'h0010}, ASD_TGT_RESERVED, 8'h00,
                    {res_tab[i], 16'h0010});
        end
        $display("test reserved done");
        @(negedge core_clk);
        rst_n = 1'b0;
        external_access_select = 1'b0;
        repeat (5) @(negedge core_clk);
        rst_n = 1'b1;
        chk("region_byte", 8'h01, data_pointer_region_byte);
        mem_chk(2'h1, 24'hff0000, ASD_TGT_EXT, ext_byte(24'hff0000), 24'hff0000);
        chk("ext_addr", 18'h30000, seen_ext ? ext_got : 18'h0);
        $display("test strap done");
        stop_test();
    end
endmodule
`default_nettype wire
